// ===== shared/fsl_map.vh
// Fault status latch constants: register offsets, field positions, reset values, timing.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef FSL_MAP_VH
`define FSL_MAP_VH

// Register byte offsets
`define FSL_CTRL_OFF        8'h00
`define FSL_STAT_OFF        8'h04
`define FSL_TRIM_OFF        8'h08
`define FSL_OSC_OFF         8'h0C

// Control fields
`define FSL_CTRL_ST_BIT     0
`define FSL_CTRL_LV_BIT     1
`define FSL_CTRL_RST        32'h00000000

// Status fields
`define FSL_STAT_LATCH_BIT  0
`define FSL_STAT_OUT_BIT    1
`define FSL_STAT_LV_BIT     2
`define FSL_STAT_CLK_BIT    3
`define FSL_STAT_PAR_BIT    4
`define FSL_STAT_STIM_BIT   5
`define FSL_STAT_VALID_BIT  6

// Trim word reset value (even parity)
`define FSL_TRIM_RST        32'h00000000

// Clock monitor: window of system clock and failure threshold range
`define FSL_CLK_HZ          200000000
`define FSL_FMIN_LO_KHZ     50
`define FSL_FMIN_HI_KHZ     260
`define FSL_WIN_US          100
`define FSL_WIN_CYC         (`FSL_WIN_US * (`FSL_CLK_HZ / 1000000))
`define FSL_FMIN_KHZ        155
`define FSL_MIN_EDGES       ((`FSL_FMIN_KHZ * `FSL_WIN_US) / 1000)

// Low-voltage trip levels in millivolts
`define FSL_LVD_MIN_MV      2700
`define FSL_LVD_TYP_MV      3250
`define FSL_LVD_MAX_MV      4000

`endif

// ===== src/fsl_sync.v
// Two-flop synchroniser for one level from outside the aclk domain.
// Assumes aclk and synchronous active-low aresetn.
`timescale 1ns/10ps
module fsl_sync (
    aclk,
    aresetn,
    async_in,
    sync_out
);
    input  wire aclk;
    input  wire aresetn;
    input  wire async_in;
    output wire sync_out;

    reg meta_r;
    reg sync_r;

    // First stage feeds only the second
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

// ===== src/fsl_fault_latch.v
// Fault detection and status latch with AXI4-Lite register access.
// Assumes one 200 MHz clock aclk, synchronous active-low aresetn, pins from outside aclk.
//
// What this block does
// RL1: The status output is the fault latch ORed with the current self-test level.
// RL2: A low-voltage detector trip sets the fault latch.
// RL3: An oscillator below the clock-monitor minimum frequency sets the fault latch.
// RL4: Odd parity over the stored trim bits sets the fault latch.
// RL5: A self-test rising edge clears the latch only when no fault condition is active.
// RL6: While self-test is high the calibrated stimulus is applied to the sensing element.
// RL7: The status output is invalid after power-up until one self-test rising edge has occurred.
// RL8: The clock monitor declares failure at a threshold between 50 kHz and 260 kHz.
// RL9: The low-voltage detector trips between 2.7 V and 4.0 V, 3.25 V typical.
// RL10: An undriven self-test input reads low, so self-test never starts by accident.
// RL11: Set beats clear in the same cycle, and self-test is synchronised before edge detection.
`timescale 1ns/10ps
`include "fsl_map.vh"
module fsl_fault_latch #(
    parameter WIN_CYC   = `FSL_WIN_CYC,
    parameter MIN_EDGES = `FSL_MIN_EDGES,
    parameter TRIM_W    = 32
) (
    aclk,
    aresetn,
    self_test_input,
    self_test_input_en,
    lvd_trip_in,
    osc_in,
    status_out,
    stimulus_en,
    status_valid,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready
);
    input  wire        aclk;
    input  wire        aresetn;
    input  wire        self_test_input;
    input  wire        self_test_input_en;
    input  wire        lvd_trip_in;
    input  wire        osc_in;
    output wire        status_out;
    output wire        stimulus_en;
    output wire        status_valid;
    input  wire [7:0]  s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output wire        s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output wire        s_axi_wready;
    output wire [1:0]  s_axi_bresp;
    output wire        s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [7:0]  s_axi_araddr;
    input  wire        s_axi_arvalid;
    output wire        s_axi_arready;
    output reg  [31:0] s_axi_rdata;
    output wire [1:0]  s_axi_rresp;
    output wire        s_axi_rvalid;
    input  wire        s_axi_rready;

    reg  [31:0] ctrl_r;
    reg  [31:0] trim_r;
    reg  [15:0] osc_cnt_r;
    reg  [15:0] osc_last_r;
    reg  [19:0] win_r;
    reg         clk_fail_r;
    reg         st_d_r;
    reg         latch_r;
    reg         valid_r;
    reg         lv_filt_r;
    reg         osc_d_r;
    reg         aw_got_r;
    reg         w_got_r;
    reg  [7:0]  aw_addr_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg         bvalid_r;
    reg  [1:0]  bresp_r;
    reg         rvalid_r;
    reg  [1:0]  rresp_r;
    reg         dec_ok;
    reg  [31:0] rd_val;
    wire        st_pin;
    wire        st_sync;
    wire        lv_sync;
    wire        osc_sync;
    wire        st_rise;
    wire        par_odd;
    wire        fault_any;
    wire        st_level;
    wire        wr_fire;
    wire        rd_fire;
    wire [31:0] w_mask;

    // Byte offsets as sized constants, so decode compares word indices bit for bit
    localparam [7:0] CTRL_OFF = `FSL_CTRL_OFF;
    localparam [7:0] STAT_OFF = `FSL_STAT_OFF;
    localparam [7:0] TRIM_OFF = `FSL_TRIM_OFF;
    localparam [7:0] OSC_OFF  = `FSL_OSC_OFF;

    // Undriven pin pulls low; enable low means nobody drives it
    assign st_pin = self_test_input_en & self_test_input; // [RL10]

    // Pins are synchronised before any logic reads them, except the enable gate on the self-test pin
    fsl_sync u_st_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (st_pin),
        .sync_out (st_sync)
    ); // [RL11]
    fsl_sync u_lv_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (lvd_trip_in),
        .sync_out (lv_sync)
    );
    fsl_sync u_osc_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (osc_in),
        .sync_out (osc_sync)
    );

    // Software can also hold self-test or force a low-voltage trip for testing
    assign st_level = st_sync | ctrl_r[`FSL_CTRL_ST_BIT];
    assign st_rise  = st_level & ~st_d_r; // [RL11]

    // Comparator output already reflects the 2.7-4.0 V trip band
    always @(posedge aclk) begin
        if (!aresetn) begin
            lv_filt_r <= 1'b0;
        end else begin
            lv_filt_r <= lv_sync | ctrl_r[`FSL_CTRL_LV_BIT]; // [RL9]
        end
    end

    // Clock monitor: count oscillator rising edges over a fixed window
    always @(posedge aclk) begin
        if (!aresetn) begin
            osc_d_r    <= 1'b0;
            osc_cnt_r  <= 16'h0000;
            osc_last_r <= 16'h0000;
            win_r      <= 20'h00000;
            clk_fail_r <= 1'b0;
        end else begin
            osc_d_r <= osc_sync;
            if (win_r == WIN_CYC[19:0] - 20'h00001) begin
                win_r      <= 20'h00000;
                osc_last_r <= osc_cnt_r;
                osc_cnt_r  <= 16'h0000;
                // Threshold sits inside the 50..260 kHz band
                clk_fail_r <= (osc_cnt_r < MIN_EDGES[15:0]); // [RL3] [RL8]
            end else begin
                win_r <= win_r + 20'h00001;
                if (osc_sync & ~osc_d_r & (osc_cnt_r != 16'hFFFF)) begin
                    osc_cnt_r <= osc_cnt_r + 16'h0001;
                end
            end
        end
    end

    // Parity over the trim store
    assign par_odd   = ^trim_r[TRIM_W-1:0]; // [RL4]
    assign fault_any = lv_filt_r | clk_fail_r | par_odd;

    // Fault latch: set wins over clear; clear needs no active fault
    always @(posedge aclk) begin
        if (!aresetn) begin
            latch_r <= 1'b0;
            st_d_r  <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            st_d_r <= st_level;
            if (fault_any) begin
                latch_r <= 1'b1; // [RL2] [RL3] [RL4] [RL11]
            end else if (st_rise) begin
                latch_r <= 1'b0; // [RL5]
            end
            if (st_rise) begin
                valid_r <= 1'b1; // [RL7]
            end
        end
    end

    assign status_out   = latch_r | st_level; // [RL1]
    assign stimulus_en  = st_level; // [RL6]
    assign status_valid = valid_r; // [RL7]

    // AXI write: address and data taken in either order, response after both
    assign s_axi_awready = ~aw_got_r & ~bvalid_r;
    assign s_axi_wready  = ~w_got_r & ~bvalid_r;
    assign wr_fire       = aw_got_r & w_got_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    // Byte-lane mask from strobes
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_mask
            assign w_mask[8*g+7:8*g] = {8{w_strb_r[g]}};
        end
    endgenerate

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'h0;
            ctrl_r    <= `FSL_CTRL_RST;
            trim_r    <= `FSL_TRIM_RST;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_got_r  <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= 2'h0;
                case (aw_addr_r[7:2])
                    CTRL_OFF[7:2]: ctrl_r <= (ctrl_r & ~w_mask) | (w_data_r & w_mask & 32'h00000003);
                    TRIM_OFF[7:2]: trim_r <= (trim_r & ~w_mask) | (w_data_r & w_mask);
                    STAT_OFF[7:2]: bresp_r <= 2'h0;
                    OSC_OFF[7:2]:  bresp_r <= 2'h0;
                    default:       bresp_r <= 2'h2;
                endcase
            end else if (bvalid_r & s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read decode
    always @* begin
        rd_val = 32'h00000000;
        dec_ok = 1'b1;
        case (s_axi_araddr[7:2])
            CTRL_OFF[7:2]: rd_val = ctrl_r;
            STAT_OFF[7:2]: begin
                rd_val[`FSL_STAT_LATCH_BIT] = latch_r;
                rd_val[`FSL_STAT_OUT_BIT]   = status_out;
                rd_val[`FSL_STAT_LV_BIT]    = lv_filt_r;
                rd_val[`FSL_STAT_CLK_BIT]   = clk_fail_r;
                rd_val[`FSL_STAT_PAR_BIT]   = par_odd;
                rd_val[`FSL_STAT_STIM_BIT]  = st_level;
                rd_val[`FSL_STAT_VALID_BIT] = valid_r;
            end
            TRIM_OFF[7:2]: rd_val = trim_r;
            OSC_OFF[7:2]:  rd_val = {16'h0000, osc_last_r};
            default:       dec_ok = 1'b0;
        endcase
    end

    // AXI read: one cycle from address to data
    assign s_axi_arready = ~rvalid_r;
    assign rd_fire       = s_axi_arvalid & ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r    <= 1'b0;
            rresp_r     <= 2'h0;
            s_axi_rdata <= 32'h00000000;
        end else if (rd_fire) begin
            rvalid_r    <= 1'b1;
            rresp_r     <= dec_ok ? 2'h0 : 2'h2;
            s_axi_rdata <= rd_val;
        end else if (rvalid_r & s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule

// ===== verification/fsl_host.sv
// Host model driving the self-test pin of the fault status latch.
// Assumes its tasks are called right after a rising aclk edge.
`timescale 1ns/10ps
module fsl_host (
    input  wire  aclk,
    output logic self_test_input,
    output logic self_test_input_en
);
    logic edge_seen;
    // Pin starts released, low through the pull-down
    initial begin
        self_test_input = 1'b0;
        self_test_input_en = 1'b0;
        edge_seen = 1'b0;
    end
    // Status is trusted only after a first rising edge
    task automatic drive(input logic lvl);
        @(posedge aclk);
        self_test_input_en <= 1'b1;
        self_test_input <= lvl;
        edge_seen <= edge_seen | lvl;
    endtask
    // Release; a high level mimics board leakage
    task automatic let_go(input logic lvl);
        @(posedge aclk);
        self_test_input_en <= 1'b0;
        self_test_input <= lvl;
    endtask
endmodule

// ===== verification/fsl_chk_sva.sv
// Checker on the fault status latch ports.
// Assumes aclk and synchronous active-low aresetn.
`timescale 1ns/10ps
module fsl_chk (
    input wire aclk,
    input wire aresetn,
    input wire self_test_input,
    input wire self_test_input_en,
    input wire lvd_trip_in,
    input wire status_out,
    input wire stimulus_en,
    input wire status_valid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_bvalid,
    input wire s_axi_bready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Pin paths allow the two-flop synchroniser delay
    a_stat_or: assert property (stimulus_en |-> status_out) else $error("status low in self-test");
    a_stim_pin: assert property ((self_test_input && self_test_input_en) [*4] |-> stimulus_en)
        else $error("no stimulus");
    a_lv_sets: assert property (lvd_trip_in [*6] |-> status_out) else $error("fault not held");
    a_latch_keep: assert property (status_out && !stimulus_en |=> status_out)
        else $error("latch cleared alone");
    a_valid_why: assert property ($rose(status_valid) |-> $past(stimulus_en)) else $error("early valid");
    a_valid_keep: assert property (status_valid |=> status_valid) else $error("valid dropped");
    // Reads answer one cycle after the request; reads and write responses one beat each
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
    a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read twice");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response twice");
endmodule
bind fsl_fault_latch fsl_chk u_chk (.*);

// ===== verification/tb_fault_status_latch.sv
// Bench for the fault status latch with host model and reference model.
// Assumes fsl_map.vh on the include path and the bound checker.
`timescale 1ns/10ps
`include "fsl_map.vh"
module tb_fault_status_latch;
    localparam int WIN = 200;
    logic        aclk = 1'b0, aresetn = 1'b0, lvd_trip_in = 1'b0, osc_in = 1'b0, osc_run = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire         self_test_input, self_test_input_en, status_out, stimulus_en, status_valid;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    int          fails = 0, n_compared = 0, m_lat = 0, m_val = 0, m_lv = 0, m_par = 0, m_clk = 0;
    integer      seed = 32'h79C2;

    fsl_host host (.*);
    fsl_fault_latch #(.WIN_CYC(WIN), .MIN_EDGES(1)) dut (.*);

    initial forever #2.5 aclk = ~aclk;
    // Oscillator at half the bus clock unless stopped
    always @(posedge aclk) if (osc_run) osc_in <= ~osc_in;

    task automatic results;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Status word the model predicts while the pin is low
    function automatic logic [31:0] stat_word();
        return {25'h0, m_val[0], 1'b0, m_par[0], m_clk[0], m_lv[0], m_lat[0], m_lat[0]};
    endfunction
    // Write: address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Self-test pulse; the latch clears only with every fault gone
    task automatic pulse();
        logic [31:0] d;
        logic [1:0]  r;
        host.drive(1'b1);
        repeat (5) @(posedge aclk);
        chk("stimulus", 32'(stimulus_en), 1);
        chk("status", 32'(status_out), 1);
        host.drive(1'b0);
        repeat (5) @(posedge aclk);
        if ((m_lv | m_par | m_clk) == 0) m_lat = 0;
        m_val = 1;
        chk("status", 32'(status_out), m_lat);
        axr(`FSL_STAT_OFF, d, r);
        chk("stat_reg", d, stat_word());
        chk("valid_host", 32'(status_valid), 32'(host.edge_seen));
    endtask

    // Hang guard, far beyond the roughly 1500 cycles of the run
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        results();
    end

    initial begin
        logic [31:0] d, v;
        logic [1:0]  r;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("valid", 32'(status_valid), 0);
        axr(`FSL_TRIM_OFF, d, r);
        chk("trim", d, `FSL_TRIM_RST);
        pulse();
        $display("reset done");
        // Low supply latches and blocks a clear while present
        lvd_trip_in <= 1'b1;
        m_lv = 1;
        m_lat = 1;
        repeat (6) @(posedge aclk);
        chk("status", 32'(status_out), 1);
        pulse();
        lvd_trip_in <= 1'b0;
        m_lv = 0;
        repeat (6) @(posedge aclk);
        pulse();
        $display("low voltage done");
        // Trim words of alternating parity; odd latches
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            v[31] = ^v[30:0] ^ i[0];
            axw(`FSL_TRIM_OFF, v, 2'b00);
            axr(`FSL_TRIM_OFF, d, r);
            chk("trim", d, v);
            m_par = ^v;
            m_lat = m_lat | m_par;
            pulse();
        end
        axw(`FSL_TRIM_OFF, 32'h0, 2'b00);
        m_par = 0;
        pulse();
        $display("parity done");
        // Stopped oscillator latches until it runs again
        osc_run <= 1'b0;
        m_clk = 1;
        m_lat = 1;
        repeat (3 * WIN) @(posedge aclk);
        pulse();
        osc_run <= 1'b1;
        m_clk = 0;
        repeat (3 * WIN) @(posedge aclk);
        pulse();
        $display("clock done");
        // Software low-voltage force latches; software self-test clears
        axw(`FSL_CTRL_OFF, 32'h2, 2'b00);
        m_lv = 1;
        m_lat = 1;
        repeat (3) @(posedge aclk);
        pulse();
        axw(`FSL_CTRL_OFF, 32'h0, 2'b00);
        m_lv = 0;
        repeat (3) @(posedge aclk);
        axw(`FSL_CTRL_OFF, 32'h1, 2'b00);
        repeat (2) @(posedge aclk);
        chk("stimulus", 32'(stimulus_en), 1);
        chk("status", 32'(status_out), 1);
        axw(`FSL_CTRL_OFF, 32'h0, 2'b00);
        m_lat = 0;
        repeat (2) @(posedge aclk);
        chk("status", 32'(status_out), 0);
        $display("software control done");
        // Leaky floating pin must not start a self-test
        host.let_go(1'b1);
        repeat (6) @(posedge aclk);
        chk("stimulus", 32'(stimulus_en), 0);
        host.drive(1'b0);
        // Unmapped read and ignored write to status
        axr(8'h40, d, r);
        chk("rresp", 32'(r), 32'(2'b10));
        axw(`FSL_STAT_OFF, 32'hFFFFFFFF, 2'b00);
        axr(`FSL_STAT_OFF, d, r);
        chk("stat_reg", d, stat_word());
        $display("pin and bus done");
        // Mid-run reset makes the status output untrusted again
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        m_lat = 0;
        m_val = 0;
        @(posedge aclk);
        chk("valid", 32'(status_valid), 0);
        axr(`FSL_STAT_OFF, d, r);
        chk("stat_reg", d, stat_word());
        pulse();
        $display("second reset done");
        results();
    end
endmodule
